// file: src/ctp_top.sv
// Purpose: compact timer with pin routing and buffered byte access
// Assumes: classic wishbone slave, 32-bit data, low byte lane used
// Notes: enhanced and standard timer outputs only routed, not generated
// Operation
// - select bit one routes pin to timer, zero keeps shared function
// - route a bits 7..4 select enhanced a and b2,b1,b0 outputs
// - route a bits 1,0 select compact out1,out0 pins
// - route b bits 5,4 compact2 outs; bits 1,0 standard outs
// - unimplemented route bits ignore writes, read zero
// - counter and compare split; low byte via shared buffer
// - compare low write only loads the buffer
// - compare high write stores high and copies buffer to low
// - high byte read returns high, captures low into buffer
// - low byte read returns the buffer
// - 10-bit up-counter advanced by internal clock or pin
// - period compares top three bits; compare a all ten
// - software only clears the counter via on bit rising
// - counter clears on overflow or comparator match
// - three modes: compare output, timer/counter, pwm
// - second output is same or inverse of first
// - on rising clears counter, falling holds value
// - period in 128-clock steps, zero gives 1024
// - mode 00 compare, 01 undefined, 10 pwm, 11 timer
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
module ctp_top
	import ctp_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	output logic ERR_O,
	input wire logic FH_TICK,
	input wire logic TBC_TICK,
	input wire logic TIMER_EXT_CLOCK_PIN,
	input wire logic [1:0] COMPACT2_OUT,
	input wire logic [1:0] STD_OUT,
	input wire logic ENH_A_OUT,
	input wire logic [2:0] ENH_B_OUT,
	input wire logic [11:0] SHARED_FN,
	output logic [11:0] PIN_OUT,
	output logic [11:0] PIN_SEL,
	output logic MATCH_A_EVT,
	output logic MATCH_P_EVT
);
	logic [7:0] ctrl0_reg, ctrl0_next;
	logic [7:0] ctrl1_reg, ctrl1_next;
	logic [7:0] route_a_reg, route_a_next;
	logic [7:0] route_b_reg, route_b_next;
	logic [7:0] buf_reg, buf_next;
	logic [7:0] cmpa_lo_reg, cmpa_lo_next;
	logic [1:0] cmpa_hi_reg, cmpa_hi_next;
	logic [7:0] evt_reg, evt_next;
	logic out_reg, out_next;
	logic on_d_reg, on_d_next;
	logic ext_s1_reg, ext_s2_reg;
	logic [31:0] dat_reg, dat_next;
	logic ack_reg, ack_next;
	logic err_reg, err_next;
	logic ma_reg, mp_reg;
	ctp_bus_e bus_reg, bus_next;
	logic req, wr, rd, lane0, hit;
	logic on_rise, on_bit, pause;
	logic [1:0] mode;
	logic [9:0] count;
	logic [11:0] fn_out;
	ctp_tick_if tk ();

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == CTP_OFF_CTRL0) || (a == CTP_OFF_CTRL1) ||
			(a == CTP_OFF_CNT_LO) || (a == CTP_OFF_CNT_HI) ||
			(a == CTP_OFF_CMPA_LO) || (a == CTP_OFF_CMPA_HI) ||
			(a == CTP_OFF_ROUTE_A) || (a == CTP_OFF_ROUTE_B) ||
			(a == CTP_OFF_STATUS);
	endfunction

	assign on_bit = ctrl0_reg[CTP_POS_ON];
	assign pause = ctrl0_reg[CTP_POS_PAUSE];
	assign mode = ctrl1_reg[7:6];
	assign on_rise = on_bit && !on_d_reg;

	ctp_clk_sel u_clk (
		.clk(CLK),
		.rst(RST),
		.sel(ctrl0_reg[6:4]),
		.fh_tick(FH_TICK),
		.tbc_tick(TBC_TICK),
		.ext_sync(ext_s2_reg),
		.tk(tk.src)
	);

	ctp_counter #(.CNT_W(CTP_CNT_W)) u_cnt (
		.clk(CLK),
		.rst(RST),
		.on(on_bit),
		.on_rise(on_rise),
		.pause(pause),
		.cclr(ctrl1_reg[CTP_POS_CCLR]),
		.period(ctrl0_reg[2:0]),
		.cmp_a({cmpa_hi_reg, cmpa_lo_reg}),
		.count(count),
		.tk(tk.dst),
		.ev(tk.ev_src)
	);

	// bus request decode; single-cycle ack, registered one clock after the request
	always_comb begin
		req = CYC_I && STB_I && (bus_reg == CTP_BUS_IDLE);
		hit = is_mapped(ADR_I);
		lane0 = SEL_I[0];
		wr = req && hit && WE_I && lane0;
		rd = req && hit && !WE_I;
		bus_next = req ? CTP_BUS_ACK : CTP_BUS_IDLE;
		ack_next = req && hit;
		err_next = req && !hit;
		dat_next = 32'h0;
		ctrl0_next = ctrl0_reg;
		ctrl1_next = ctrl1_reg;
		route_a_next = route_a_reg;
		route_b_next = route_b_reg;
		buf_next = buf_reg;
		cmpa_lo_next = cmpa_lo_reg;
		cmpa_hi_next = cmpa_hi_reg;
		if (wr) begin
			unique case (ADR_I)
				CTP_OFF_CTRL0: ctrl0_next = DAT_I[7:0];
				CTP_OFF_CTRL1: ctrl1_next = DAT_I[7:0];
				CTP_OFF_CMPA_LO: buf_next = DAT_I[7:0];
				CTP_OFF_CMPA_HI: begin
					cmpa_hi_next = DAT_I[1:0];
					cmpa_lo_next = buf_reg;
				end
				CTP_OFF_ROUTE_A:
					route_a_next = DAT_I[7:0] & CTP_ROUTE_A_MASK;
				CTP_OFF_ROUTE_B:
					route_b_next = DAT_I[7:0] & CTP_ROUTE_B_MASK;
				default: ;
			endcase
		end
		if (rd) begin
			unique case (ADR_I)
				CTP_OFF_CTRL0: dat_next[7:0] = ctrl0_reg;
				CTP_OFF_CTRL1: dat_next[7:0] = ctrl1_reg;
				CTP_OFF_CNT_LO, CTP_OFF_CMPA_LO:
					dat_next[7:0] = buf_reg;
				CTP_OFF_CNT_HI: begin
					dat_next[1:0] = count[9:8];
					buf_next = count[7:0];
				end
				CTP_OFF_CMPA_HI: begin
					dat_next[1:0] = cmpa_hi_reg;
					buf_next = cmpa_lo_reg;
				end
				CTP_OFF_ROUTE_A: dat_next[7:0] = route_a_reg;
				CTP_OFF_ROUTE_B: dat_next[7:0] = route_b_reg;
				CTP_OFF_STATUS: dat_next[7:0] = evt_reg;
				default: ;
			endcase
		end
	end

	// sticky events; a new event wins over the read-clear
	always_comb begin
		evt_next = evt_reg;
		if (rd && ADR_I == CTP_OFF_STATUS)
			evt_next = 8'h00;
		if (tk.match_a)
			evt_next[0] = 1'b1;
		if (tk.match_p)
			evt_next[1] = 1'b1;
		if (tk.overflow)
			evt_next[2] = 1'b1;
	end

	// output stage per mode
	always_comb begin
		on_d_next = on_bit;
		out_next = out_reg;
		unique case (mode)
			CTP_MODE_CMP: begin
				if (on_rise)
					out_next = ctrl1_reg[CTP_POS_OC];
				else if (tk.match_a) begin
					unique case (ctrl1_reg[5:4])
						2'h0: out_next = out_reg;
						2'h1: out_next = 1'b0;
						2'h2: out_next = 1'b1;
						2'h3: out_next = !out_reg;
					endcase
				end
			end
			CTP_MODE_PWM: begin
				unique case (ctrl1_reg[5:4])
					2'h0: out_next = !ctrl1_reg[CTP_POS_OC];
					2'h1: out_next = ctrl1_reg[CTP_POS_OC];
					2'h2: out_next = (count < {cmpa_hi_reg, cmpa_lo_reg}) ?
						ctrl1_reg[CTP_POS_OC] : !ctrl1_reg[CTP_POS_OC];
					2'h3: out_next = out_reg;
				endcase
			end
			CTP_MODE_UNDEF, CTP_MODE_TMR: out_next = out_reg;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl0_reg <= CTP_CTRL_RST;
			ctrl1_reg <= CTP_CTRL_RST;
			route_a_reg <= CTP_ROUTE_A_RST;
			route_b_reg <= CTP_ROUTE_B_RST;
			buf_reg <= 8'h00;
			cmpa_lo_reg <= 8'h00;
			cmpa_hi_reg <= 2'h0;
			evt_reg <= 8'h00;
			out_reg <= 1'b0;
			on_d_reg <= 1'b0;
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			dat_reg <= 32'h0;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			ma_reg <= 1'b0;
			mp_reg <= 1'b0;
			bus_reg <= CTP_BUS_IDLE;
		end else begin
			ctrl0_reg <= ctrl0_next;
			ctrl1_reg <= ctrl1_next;
			route_a_reg <= route_a_next;
			route_b_reg <= route_b_next;
			buf_reg <= buf_next;
			cmpa_lo_reg <= cmpa_lo_next;
			cmpa_hi_reg <= cmpa_hi_next;
			evt_reg <= evt_next;
			out_reg <= out_next;
			on_d_reg <= on_d_next;
			ext_s1_reg <= TIMER_EXT_CLOCK_PIN;
			ext_s2_reg <= ext_s1_reg;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
			err_reg <= err_next;
			ma_reg <= tk.match_a;
			mp_reg <= tk.match_p;
			bus_reg <= bus_next;
		end
	end

	// pin order: 0 cmp0,1 cmp1,2 enh_b0,3 enh_b1,4 enh_b2,5 enh_a,
	// 6 std0,7 std1,8 c2_0,9 c2_1,10..11 spare
	always_comb begin
		fn_out[0] = out_reg;
		fn_out[1] = ctrl1_reg[CTP_POS_DPX] ? !out_reg : out_reg;
		fn_out[4:2] = ENH_B_OUT;
		fn_out[5] = ENH_A_OUT;
		fn_out[7:6] = STD_OUT;
		fn_out[9:8] = COMPACT2_OUT;
		fn_out[11:10] = 2'h0;
		PIN_SEL[1:0] = route_a_reg[1:0];
		PIN_SEL[4:2] = route_a_reg[6:4];
		PIN_SEL[5] = route_a_reg[7];
		PIN_SEL[7:6] = route_b_reg[1:0];
		PIN_SEL[9:8] = route_b_reg[5:4];
		PIN_SEL[11:10] = 2'h0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++) begin : g_pin
			assign PIN_OUT[gi] = PIN_SEL[gi] ? fn_out[gi] :
				SHARED_FN[gi];
		end
	endgenerate

	assign DAT_O = dat_reg;
	assign ACK_O = ack_reg;
	assign ERR_O = err_reg;
	assign MATCH_A_EVT = ma_reg;
	assign MATCH_P_EVT = mp_reg;
endmodule // ctp_top

// file: src/ctp_pkg.sv
// Purpose: shared constants and types for the compact timer block
// Assumes: 32-bit classic wishbone, word-aligned registers
// Notes: offsets are byte addresses
package ctp_pkg;
	localparam logic [7:0] CTP_OFF_CTRL0 = 8'h00;
	localparam logic [7:0] CTP_OFF_CTRL1 = 8'h04;
	localparam logic [7:0] CTP_OFF_CNT_LO = 8'h08;
	localparam logic [7:0] CTP_OFF_CNT_HI = 8'h0c;
	localparam logic [7:0] CTP_OFF_CMPA_LO = 8'h10;
	localparam logic [7:0] CTP_OFF_CMPA_HI = 8'h14;
	localparam logic [7:0] CTP_OFF_ROUTE_A = 8'h18;
	localparam logic [7:0] CTP_OFF_ROUTE_B = 8'h1c;
	localparam logic [7:0] CTP_OFF_STATUS = 8'h20;
	localparam logic [7:0] CTP_ROUTE_A_MASK = 8'hf3;
	localparam logic [7:0] CTP_ROUTE_B_MASK = 8'h33;
	localparam logic [7:0] CTP_ROUTE_A_RST = 8'h91;
	localparam logic [7:0] CTP_ROUTE_B_RST = 8'h11;
	localparam logic [7:0] CTP_CTRL_RST = 8'h00;
	localparam int CTP_CNT_W = 10;
	localparam int CTP_POS_PAUSE = 7;
	localparam int CTP_POS_ON = 3;
	localparam int CTP_POS_CCLR = 0;
	localparam int CTP_POS_DPX = 1;
	localparam int CTP_POS_POL = 2;
	localparam int CTP_POS_OC = 3;
	localparam logic [1:0] CTP_MODE_CMP = 2'h0;
	localparam logic [1:0] CTP_MODE_UNDEF = 2'h1;
	localparam logic [1:0] CTP_MODE_PWM = 2'h2;
	localparam logic [1:0] CTP_MODE_TMR = 2'h3;
	localparam logic [2:0] CTP_CK_SYS4 = 3'h0;
	localparam logic [2:0] CTP_CK_SYS = 3'h1;
	localparam logic [2:0] CTP_CK_H16 = 3'h2;
	localparam logic [2:0] CTP_CK_H64 = 3'h3;
	localparam logic [2:0] CTP_CK_TBC = 3'h4;
	localparam logic [2:0] CTP_CK_RES = 3'h5;
	localparam logic [2:0] CTP_CK_PIN_R = 3'h6;
	localparam logic [2:0] CTP_CK_PIN_F = 3'h7;
	localparam logic [5:0] CTP_PRESC_MAX = 6'h3f;
	typedef enum logic [1:0] {
		CTP_BUS_IDLE = 2'b00,
		CTP_BUS_ACK = 2'b01
	} ctp_bus_e;
endpackage

// file: src/ctp_tick_if.sv
// Purpose: carries counter advance tick and match events between modules
// Assumes: one clock domain
// Notes: none
`timescale 1ns/10ps
interface ctp_tick_if;
	logic tick;
	logic match_a;
	logic match_p;
	logic overflow;
	modport src (output tick);
	modport dst (input tick);
	modport ev_src (output match_a, output match_p, output overflow);
	modport ev_dst (input match_a, input match_p, input overflow);
endinterface

// file: src/ctp_clk_sel.sv
// Purpose: timer clock source selection into a single-cycle tick
// Assumes: ext pin already synchronised, fh and ftbc ticks are enables
// Notes: reserved code never ticks
`timescale 1ns/10ps
module ctp_clk_sel
	import ctp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] sel,
	input wire logic fh_tick,
	input wire logic tbc_tick,
	input wire logic ext_sync,
	ctp_tick_if.src tk
);
	logic [5:0] presc_reg, presc_next;
	logic [5:0] hdiv_reg, hdiv_next;
	logic ext_reg, ext_next;
	logic tick_c;

	always_comb begin
		presc_next = presc_reg + 6'h01;
		hdiv_next = fh_tick ? hdiv_reg + 6'h01 : hdiv_reg;
		ext_next = ext_sync;
		unique case (sel)
			CTP_CK_SYS4: tick_c = (presc_reg[1:0] == 2'h3);
			CTP_CK_SYS: tick_c = 1'b1;
			CTP_CK_H16: tick_c = fh_tick && (hdiv_reg[3:0] == 4'hf);
			CTP_CK_H64: tick_c = fh_tick && (hdiv_reg == CTP_PRESC_MAX);
			CTP_CK_TBC: tick_c = tbc_tick;
			CTP_CK_RES: tick_c = 1'b0;
			CTP_CK_PIN_R: tick_c = ext_sync && !ext_reg;
			CTP_CK_PIN_F: tick_c = !ext_sync && ext_reg;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_reg <= 6'h00;
			hdiv_reg <= 6'h00;
			ext_reg <= 1'b0;
		end else begin
			presc_reg <= presc_next;
			hdiv_reg <= hdiv_next;
			ext_reg <= ext_next;
		end
	end

	assign tk.tick = tick_c;
endmodule // ctp_clk_sel

// file: src/ctp_counter.sv
// Purpose: 10-bit up-counter with period and compare-a comparators
// Assumes: tick is a one-cycle enable
// Notes: counter cannot be loaded, only cleared
`timescale 1ns/10ps
module ctp_counter
	import ctp_pkg::*;
#(
	parameter int CNT_W = CTP_CNT_W
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic on,
	input wire logic on_rise,
	input wire logic pause,
	input wire logic cclr,
	input wire logic [2:0] period,
	input wire logic [CNT_W-1:0] cmp_a,
	output logic [CNT_W-1:0] count,
	ctp_tick_if.dst tk,
	ctp_tick_if.ev_src ev
);
	logic [CNT_W-1:0] cnt_reg, cnt_next, cnt_inc;
	logic adv, m_a, m_p, ovf;

	// period compare needs three top bits above a low field
	if (CNT_W < 4) begin : g_bad_width
		$error("counter width too small");
	end

	always_comb begin
		adv = on && !pause && tk.tick;
		cnt_inc = cnt_reg + 1'b1;
		// period zero compares as full wrap; matching the count about to
		// be reached keeps a period at whole 128-clock steps
		m_p = adv && (period != 3'h0) &&
			(cnt_inc[CNT_W-1 -: 3] == period) &&
			(cnt_inc[CNT_W-4:0] == '0);
		m_a = adv && (cnt_reg == cmp_a);
		ovf = adv && (&cnt_reg);
		cnt_next = cnt_reg;
		if (on_rise)
			cnt_next = '0;
		else if (adv) begin
			if (ovf || (cclr ? m_a : m_p))
				cnt_next = '0;
			else
				cnt_next = cnt_inc;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign count = cnt_reg;
	assign ev.match_a = m_a;
	assign ev.match_p = m_p;
	assign ev.overflow = ovf;
endmodule // ctp_counter

// file: bench/ctp_top_asserts.sv
// Purpose: port-level checks of the compact timer block
// Assumes: one clock, bus request held until answered
// Notes: timer-driven pins 0, 1 checked only while not routed
`timescale 1ns/10ps
module ctp_top_asserts (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_O,
	input wire logic ACK_O,
	input wire logic ERR_O,
	input wire logic [1:0] COMPACT2_OUT,
	input wire logic [1:0] STD_OUT,
	input wire logic ENH_A_OUT,
	input wire logic [2:0] ENH_B_OUT,
	input wire logic [11:0] SHARED_FN,
	input wire logic [11:0] PIN_OUT,
	input wire logic [11:0] PIN_SEL
);
	logic [7:0] oth;
	assign oth = {COMPACT2_OUT, STD_OUT, ENH_A_OUT, ENH_B_OUT};
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_take;
		CYC_I && STB_I && !ACK_O && !ERR_O;
	endsequence
	sequence s_rd(logic [7:0] a);
		s_take ##0 !WE_I && ADR_I == a;
	endsequence
	a_ack_one: assert property (s_take |=> (ACK_O != ERR_O) ##1
		(!ACK_O && !ERR_O)) else $error("bus answer not one pulse");
	a_err_unmapped: assert property (
		s_take ##0 ADR_I >= 8'h24 |=> ERR_O && !ACK_O)
		else $error("unmapped address not refused");
	a_route_a_zero: assert property (
		s_rd(8'h18) |=> (DAT_O & 32'hffffff0c) == 32'h0)
		else $error("route a spare bits not zero");
	a_route_b_zero: assert property (
		s_rd(8'h1c) |=> (DAT_O & 32'hffffffcc) == 32'h0)
		else $error("route b spare bits not zero");
	a_hi_narrow: assert property (
		s_rd(8'h0c) or s_rd(8'h14) |=> DAT_O[31:2] == 30'h0)
		else $error("high byte wider than two bits");
	a_sel_by_write: assert property (
		!$stable(PIN_SEL) |-> $past(CYC_I && STB_I && WE_I))
		else $error("pin select changed without write");
	a_other_mux: assert property (PIN_OUT[9:2] ==
		((oth & PIN_SEL[9:2]) | (SHARED_FN[9:2] & ~PIN_SEL[9:2])))
		else $error("routed pin mux wrong");
	a_compact_keep: assert property (
		(PIN_OUT[1:0] & ~PIN_SEL[1:0]) == (SHARED_FN[1:0] & ~PIN_SEL[1:0]))
		else $error("compact pin lost shared function");
	a_spare_pins: assert property (PIN_SEL[11:10] == 2'h0 &&
		PIN_OUT[11:10] == SHARED_FN[11:10])
		else $error("spare pins not shared");
	a_data_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
		else $error("read data outside answer");
endmodule // ctp_top_asserts

// file: bench/ctp_cpu_model.sv
// Purpose: cpu-side classic wishbone master for the timer registers
// Assumes: each task is entered just after a rising edge
// Notes: waits for ack or err without limit; bench timeout covers hangs
`timescale 1ns/10ps
module ctp_cpu_model (
	input wire logic clk,
	input wire logic ack,
	input wire logic err,
	input wire logic [31:0] dat_in,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat
);
	initial {cyc, stb, we, adr, sel, dat} = 47'h0;
	task automatic bus(input logic w, input logic [7:0] a, d,
		output logic [7:0] q, output logic e);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h1, 24'h0, d};
		do @(posedge clk); while (!(ack || err));
		q = dat_in[7:0];
		e = err;
		// released address and data inverted, strobes dropped, so stale values never look valid
		{cyc, stb, we, adr, dat} <= {3'h0, ~a, ~dat};
		@(posedge clk);
	endtask
	task automatic wr16(input logic [7:0] lo, input logic [9:0] v);
		logic [7:0] q;
		logic e;
		bus(1'b1, lo, v[7:0], q, e);
		bus(1'b1, lo + 8'h4, {6'h0, v[9:8]}, q, e);
	endtask
	task automatic rd16(input logic [7:0] hi, output logic [9:0] v);
		logic [7:0] h;
		logic [7:0] l;
		logic e;
		bus(1'b0, hi, 8'h0, h, e);
		bus(1'b0, hi - 8'h4, 8'h0, l, e);
		v = {h[1:0], l};
	endtask
endmodule // ctp_cpu_model

// file: bench/ctp_top_test.sv
// Purpose: self-checking bench for the compact timer block
// Assumes: counter clocked from the system clock or the pin
// Notes: other-timer outputs and shared functions are random
`timescale 1ns/10ps
module ctp_top_test import ctp_pkg::*;;
	logic clk, rst, cyc, stb, we, ack, err, fh, tbc, ext, ea, ma, mp;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r;
	logic [1:0] c2, sto;
	logic [2:0] eb;
	logic [11:0] shf, pin_out, pin_sel;
	integer seed = 64;
	int failures = 0;
	int checks = 0;
	int cyc_n = 0;
	ctp_top ctp_top_i (.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
		.ACK_O(ack), .ERR_O(err), .FH_TICK(fh), .TBC_TICK(tbc),
		.TIMER_EXT_CLOCK_PIN(ext), .COMPACT2_OUT(c2), .STD_OUT(sto),
		.ENH_A_OUT(ea), .ENH_B_OUT(eb), .SHARED_FN(shf), .PIN_OUT(pin_out),
		.PIN_SEL(pin_sel), .MATCH_A_EVT(ma), .MATCH_P_EVT(mp));
	ctp_cpu_model ctp_cpu_model_i (.clk(clk), .ack(ack), .err(err),
		.dat_in(dat_r), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(dat_w));
	function logic [11:0] exp_sel(logic [7:0] a, logic [7:0] b);
		return {2'b00, b[5:4], b[1:0], a[7], a[6:4], a[1:0]};
	endfunction
	task chk(input string n, input logic [11:0] x, input logic [11:0] g);
		checks++;
		if (g !== x) begin
			failures++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task print_verdict;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] q);
		logic e;
		ctp_cpu_model_i.bus(1'b0, a, 8'h0, q, e);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		ctp_cpu_model_i.bus(1'b1, a, d, q, e);
	endtask
	task gap(input logic p, output int d);
		int t;
		do @(posedge clk); while (!(p ? mp : ma));
		t = cyc_n;
		do @(posedge clk); while (!(p ? mp : ma));
		d = cyc_n - t;
	endtask
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		{fh, tbc, c2, sto, ea, eb, shf} <= 22'($random(seed));
		// ceiling well above the few thousand cycles the run needs
		if (cyc_n == 20000) begin
			failures++;
			print_verdict;
		end
	end
	initial begin
		logic [7:0] q, ra, rb;
		logic [9:0] v, w;
		logic [1:0] p;
		logic e;
		int d;
		rst = 1;
		ext = 0;
		{fh, tbc, c2, sto, ea, eb, shf} = 22'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pin_sel", 12'h165, pin_sel);
		for (int i = 0; i < 6; i++) begin
			ra = i == 0 ? 8'hff : 8'($random(seed));
			rb = i == 0 ? 8'hff : 8'($random(seed));
			wr(CTP_OFF_ROUTE_A, ra);
			wr(CTP_OFF_ROUTE_B, rb);
			rd(CTP_OFF_ROUTE_A, q);
			chk("route_a", 12'(ra & CTP_ROUTE_A_MASK), 12'(q));
			rd(CTP_OFF_ROUTE_B, q);
			chk("route_b", 12'(rb & CTP_ROUTE_B_MASK), 12'(q));
			chk("pin_sel", exp_sel(ra, rb), pin_sel);
		end
		ctp_cpu_model_i.bus(1'b0, 8'h24, 8'h0, q, e);
		chk("err", 12'h1, 12'(e));
		for (int i = 0; i < 4; i++) begin
			wr(CTP_OFF_CTRL1, 8'(i << 6) | 8'h3e);
			rd(CTP_OFF_CTRL1, q);
			chk("ctrl1", 12'(8'(i << 6) | 8'h3e), 12'(q));
		end
		ctp_cpu_model_i.wr16(CTP_OFF_CMPA_LO, 10'h25a);
		wr(CTP_OFF_CMPA_LO, 8'ha5);
		ctp_cpu_model_i.rd16(CTP_OFF_CMPA_HI, v);
		chk("cmp_a", 12'h25a, 12'(v));
		wr(CTP_OFF_CMPA_LO, 8'h33);
		rd(CTP_OFF_CMPA_LO, q);
		chk("buffer", 12'h33, 12'(q));
		wr(CTP_OFF_CMPA_HI, 8'h01);
		ctp_cpu_model_i.rd16(CTP_OFF_CMPA_HI, v);
		chk("cmp_a", 12'h133, 12'(v));
		wr(CTP_OFF_ROUTE_A, 8'h03);
		// compare mode, toggle on match a, initial high, inverted 2nd pin
		wr(CTP_OFF_CTRL1, 8'h3a);
		ctp_cpu_model_i.wr16(CTP_OFF_CMPA_LO, 10'h040);
		wr(CTP_OFF_CTRL0, 8'h19);
		chk("pin_cmp", 12'h1, 12'(pin_out[1:0]));
		gap(1'b1, d);
		chk("p_gap", 12'd128, 12'(d));
		gap(1'b0, d);
		chk("a_gap", 12'd128, 12'(d));
		p = ~pin_out[1:0];
		do @(posedge clk); while (!ma);
		chk("toggle", 12'(p), 12'(pin_out[1:0]));
		wr(CTP_OFF_CTRL0, 8'h18);
		gap(1'b0, d);
		chk("wrap_gap", 12'd1024, 12'(d));
		rd(CTP_OFF_STATUS, q);
		chk("status", 12'h7, 12'(q));
		wr(CTP_OFF_CTRL0, 8'h10);
		ctp_cpu_model_i.rd16(CTP_OFF_CNT_HI, v);
		repeat (20) @(posedge clk);
		ctp_cpu_model_i.rd16(CTP_OFF_CNT_HI, w);
		chk("held", 12'(v), 12'(w));
		wr(CTP_OFF_CTRL0, 8'h58);
		ctp_cpu_model_i.rd16(CTP_OFF_CNT_HI, v);
		chk("cleared", 12'h0, 12'(v));
		// rising then falling pin edge as the counter clock
		for (int m = 0; m < 2; m++) begin
			wr(CTP_OFF_CTRL0, 8'h10);
			wr(CTP_OFF_CTRL0, m == 0 ? 8'h68 : 8'h78);
			repeat (5) begin
				repeat (4) @(posedge clk);
				ext <= 1'b1;
				repeat (4) @(posedge clk);
				ext <= 1'b0;
			end
			repeat (6) @(posedge clk);
			ctp_cpu_model_i.rd16(CTP_OFF_CNT_HI, v);
			chk("pin_count", 12'h5, 12'(v));
		end
		print_verdict;
	end
endmodule // ctp_top_test
bind ctp_top ctp_top_asserts ctp_top_asserts_i (.CLK(CLK), .RST(RST),
	.CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O),
	.COMPACT2_OUT(COMPACT2_OUT), .STD_OUT(STD_OUT), .ENH_A_OUT(ENH_A_OUT),
	.ENH_B_OUT(ENH_B_OUT), .SHARED_FN(SHARED_FN), .PIN_OUT(PIN_OUT),
	.PIN_SEL(PIN_SEL));
